// ### mrb_pkg.sv
// Constants shared by the motor status readback register bank.
// Assumes one 20 MHz system clock and the two-wire slave port in the top.
package mrb_pkg;

    // Two-wire slave address
    localparam logic [6:0] SLAVE_ADDR = 7'h52;

    // Register offsets
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_ROTATION_RATE = 8'h01;
    localparam logic [7:0] ADDR_ELECTRICAL_PERIOD = 8'h02;
    localparam logic [7:0] ADDR_VELOCITY_CONSTANT = 8'h03;
    localparam logic [7:0] ADDR_WINDING_CURRENT = 8'h04;
    localparam logic [7:0] ADDR_POSITION_AND_SUPPLY = 8'h05;
    localparam logic [7:0] ADDR_SPEED_REQUEST_AND_BUFFER = 8'h06;
    localparam logic [7:0] ADDR_ANALOG_INPUT_LEVEL = 8'h07;
    localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h08;
    localparam logic [7:0] ADDR_RW_BASE = 8'h30;
    localparam logic [7:0] ADDR_NV_BASE = 8'h90;
    localparam int RW_COUNT = 7;
    localparam int NV_COUNT = 7;

    // Fault flags: bit 6 reserved, clear key
    localparam logic [15:0] FAULT_VALID_MASK = 16'hffbf;
    localparam logic [7:0] FAULT_CLEAR_KEY = 8'hff;

    // Speed setpoint fields
    localparam int SETPOINT_MANUAL_SPEED_SELECT_BIT = 15;
    localparam logic [15:0] SETPOINT_VALUE_MASK = 16'h81ff;

    // Nonvolatile-backed defaults, entry 0 in the low word
    localparam logic [NV_COUNT*16-1:0] NV_DEFAULTS = {
        16'h016a, 16'h3c43, 16'h3faf, 16'h1b8a, 16'h0050, 16'h2f3b, 16'h1048
    };
    localparam int NV_ADV_SEL_ENTRY = 6;
    localparam int NV_ADV_SEL_LSB = 14;

    // Identity values, arbitrary
    localparam logic [7:0] DIE_IDENTIFIER = 8'h5a;
    localparam logic [7:0] SILICON_REVISION_CODE = 8'h01;

    // Speed source selection
    typedef enum logic [1:0] {
        SRC_PWM = 2'h0,
        SRC_ANALOG = 2'h1,
        SRC_SERIAL = 2'h2
    } mrb_speed_src_type;

    // Period register unit and its cycle count
    localparam int CLK_PERIOD_NS = 50;
    localparam int PERIOD_UNIT_NS = 10000;
    localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_NS / CLK_PERIOD_NS;

    // Start-position table
    localparam logic [8*6-1:0] SECTOR_BASE = {8'hd5, 8'hab, 8'h80, 8'h55, 8'h2b, 8'h00};
    localparam logic [8*4-1:0] ADVANCE_TERM = {8'h55, 8'h3f, 8'h2c, 8'h16};

    // Two-wire slave states, Gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV_ADDR = 4'h1,
        ST_DEV_ACK = 4'h3,
        ST_REG_ADDR = 4'h2,
        ST_REG_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RACK = 4'hc
    } mrb_state_type;

endpackage : mrb_pkg

// ### mrb_position_code.sv
// Start-position code: sector base plus advance term, wrapping at 256.
// Pure combinational; the top registers the result.
`timescale 1ns/10ps
module mrb_position_code (
    input wire logic [2:0] i_sector,
    input wire logic [1:0] i_advance_sel,
    output logic [7:0] o_code
);
    logic [7:0] base;
    logic [7:0] adv;

    always_comb begin
        // Sectors 6 and 7 do not exist; fold to sector 0
        if (i_sector < 3'h6) begin
            base = mrb_pkg::SECTOR_BASE[i_sector*8 +: 8];
        end else begin
            base = 8'h00;
        end
        adv = mrb_pkg::ADVANCE_TERM[i_advance_sel*8 +: 8];
        o_code = base + adv;
    end
endmodule : mrb_position_code

// ### mrb_period_meter.sv
// Electrical period meter in 10 us units between phase U zero crossings.
// Assumes the zero-crossing strobe is a one-cycle pulse.
`timescale 1ns/10ps
module mrb_period_meter (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_spinning,
    input wire logic i_zero_cross_u,
    output logic o_update,
    output logic [15:0] o_period
);
    localparam logic [7:0] TICK_LAST = 8'(mrb_pkg::PERIOD_UNIT_CYCLES - 1);
    logic [7:0] tick_q;
    logic [15:0] count_q;
    logic seen_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_q <= 8'h00;
            count_q <= 16'h0000;
            seen_q <= 1'b0;
            o_update <= 1'b0;
            o_period <= 16'h0000;
        end else begin
            o_update <= 1'b0;
            if (!i_spinning) begin
                // First crossing after a stop only restarts the count
                seen_q <= 1'b0;
                tick_q <= 8'h00;
                count_q <= 16'h0000;
            end else if (i_zero_cross_u) begin
                seen_q <= 1'b1;
                tick_q <= 8'h00;
                count_q <= 16'h0000;
                if (seen_q) begin
                    o_update <= 1'b1;
                    o_period <= count_q;
                end
            end else if (tick_q == TICK_LAST) begin
                tick_q <= 8'h00;
                // Saturate rather than wrap on a very slow rotor
                if (count_q != 16'hffff) begin
                    count_q <= count_q + 16'h0001;
                end
            end else begin
                tick_q <= tick_q + 8'h01;
            end
        end
    end
endmodule : mrb_period_meter

// ### mrb_readback_regs.sv
// Status readback and host register bank with its two-wire serial slave.
// Assumes SCL and SDA arrive synchronous to i_sys_clk, SDA open drain.
//
// How it works
// - While spinning, the period register is refreshed with the time between U crossings.
// - While spinning, each per-cycle back-EMF integration result is stored in the velocity reg.
// - The velocity code means volts per hertz as code over two over 1090, passed through as is.
// - On position-detect completion the sector position is stored in the start-position field.
// - Sectors 0 to 300 degrees take base values 0, 43, 85, 128, 171 and 213.
// - The stored position adds 22, 44, 63 or 85 for the advance angle, modulo 256.
// - During operation each supply sample is stored as an 8-bit code of 30 V over 256 steps.
// - The active speed input, PWM, analog or serial, becomes one readable speed request value.
// - The speed request is an 8-bit code, percent equal to code times 100 over 255.
// - The buffered field shows the applied maximum duty, which may differ from the request.
// - The serial slave answers at 7-bit address 101 0010.
// - Addresses 0x30 to 0x36 are read/write host control registers.
// - Addresses 0x00 to 0x08 are read-only status; writes do not alter measured values.
// - Addresses 0x90 to 0x96 hold nonvolatile-backed motor and spin-up settings.
// - Fault flags stay set until the host writes 0xFF to the fault register.
`timescale 1ns/10ps
module mrb_readback_regs (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_spinning,
    input wire logic i_zero_cross_u,
    input wire logic i_kt_done,
    input wire logic [15:0] i_kt_result,
    input wire logic i_ipd_done,
    input wire logic [2:0] i_ipd_sector,
    input wire logic i_supply_sample,
    input wire logic [7:0] i_supply_code,
    input wire logic [1:0] i_speed_src,
    input wire logic [7:0] i_pwm_duty_code,
    input wire logic [9:0] i_analog_adc,
    input wire logic [7:0] i_applied_duty,
    input wire logic [15:0] i_rotation_rate,
    input wire logic [10:0] i_winding_current,
    input wire logic [15:0] i_fault_events,
    output logic [7:0] o_speed_request_value,
    output logic o_manual_speed_select,
    output logic [15:0] o_nvm_unlock_key
);
    // Sampled bus lines
    logic scl_q;
    logic sda_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic bus_start;
    logic bus_stop;
    logic scl_rise;
    logic scl_fall;

    // Slave engine
    mrb_pkg::mrb_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic [7:0] wr_high_q;
    logic [15:0] rd_word_q;
    logic rd_dir_q;
    logic low_byte_q;
    logic nack_q;
    logic wr_stb_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata;

    // Status storage
    logic [15:0] fault_q;
    logic [15:0] period_val;
    logic [15:0] kt_q;
    logic [7:0] position_q;
    logic [7:0] position_code;
    logic [7:0] supply_q;
    logic [7:0] applied_q;
    logic [15:0] rate_q;
    logic [10:0] current_q;
    logic [9:0] analog_q;
    localparam int RW_BITS = mrb_pkg::RW_COUNT * 16;
    localparam int NV_BITS = mrb_pkg::NV_COUNT * 16;
    logic [RW_BITS-1:0] rw_q;
    logic [NV_BITS-1:0] nv_q;
    logic fault_clear;

    assign bus_start = scl_q && sda_prev_q && !sda_q;
    assign bus_stop = scl_q && !sda_prev_q && sda_q;
    assign scl_rise = scl_q && !scl_prev_q;
    assign scl_fall = !scl_q && scl_prev_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            o_sda_out <= 1'b0;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
            o_sda_out <= 1'b0;
        end
    end

    // Slave engine; SDA only changes after SCL falls
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= mrb_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            wr_high_q <= 8'h00;
            rd_word_q <= 16'h0000;
            rd_dir_q <= 1'b0;
            low_byte_q <= 1'b0;
            nack_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wdata_q <= 16'h0000;
            o_sda_oe <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            if (bus_stop) begin
                state_q <= mrb_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (bus_start) begin
                // Repeated start keeps the register pointer
                state_q <= mrb_pkg::ST_DEV_ADDR;
                bit_cnt_q <= 4'h0;
                low_byte_q <= 1'b0;
                o_sda_oe <= 1'b0;
            end else begin
                if (scl_rise) begin
                    shift_q <= {shift_q[6:0], sda_q};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                case (state_q)
                    mrb_pkg::ST_DEV_ADDR: begin
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (shift_q[7:1] == mrb_pkg::SLAVE_ADDR) begin
                                rd_dir_q <= shift_q[0];
                                o_sda_oe <= 1'b1;
                                state_q <= mrb_pkg::ST_DEV_ACK;
                            end else begin
                                state_q <= mrb_pkg::ST_IDLE;
                            end
                        end
                    end
                    mrb_pkg::ST_DEV_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rd_dir_q) begin
                                // Snapshot whole word so both bytes agree
                                rd_word_q <= rdata;
                                tx_q <= rdata[15:8];
                                o_sda_oe <= !rdata[15];
                                low_byte_q <= 1'b1;
                                state_q <= mrb_pkg::ST_RDATA;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_q <= mrb_pkg::ST_REG_ADDR;
                            end
                        end
                    end
                    mrb_pkg::ST_REG_ADDR: begin
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            ptr_q <= shift_q;
                            low_byte_q <= 1'b0;
                            o_sda_oe <= 1'b1;
                            state_q <= mrb_pkg::ST_REG_ACK;
                        end
                    end
                    mrb_pkg::ST_REG_ACK, mrb_pkg::ST_WACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            o_sda_oe <= 1'b0;
                            state_q <= mrb_pkg::ST_WDATA;
                        end
                    end
                    mrb_pkg::ST_WDATA: begin
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            o_sda_oe <= 1'b1;
                            state_q <= mrb_pkg::ST_WACK;
                            if (!low_byte_q) begin
                                wr_high_q <= shift_q;
                                low_byte_q <= 1'b1;
                            end else begin
                                wdata_q <= {wr_high_q, shift_q};
                                wr_stb_q <= 1'b1;
                                low_byte_q <= 1'b0;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    mrb_pkg::ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                bit_cnt_q <= 4'h0;
                                o_sda_oe <= 1'b0;
                                state_q <= mrb_pkg::ST_RACK;
                                if (!low_byte_q) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                o_sda_oe <= !tx_q[6];
                            end
                        end
                    end
                    mrb_pkg::ST_RACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_q;
                        end
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (nack_q) begin
                                // Host ends the read; wait for stop
                                state_q <= mrb_pkg::ST_IDLE;
                            end else if (low_byte_q) begin
                                tx_q <= rd_word_q[7:0];
                                o_sda_oe <= !rd_word_q[7];
                                low_byte_q <= 1'b0;
                                state_q <= mrb_pkg::ST_RDATA;
                            end else begin
                                rd_word_q <= rdata;
                                tx_q <= rdata[15:8];
                                o_sda_oe <= !rdata[15];
                                low_byte_q <= 1'b1;
                                state_q <= mrb_pkg::ST_RDATA;
                            end
                        end
                    end
                    default: begin
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Fault flags, set wins over a same-cycle clear
    assign fault_clear = wr_stb_q && (ptr_q - 8'h01 == mrb_pkg::ADDR_FAULT_FLAGS)
        && (wdata_q[7:0] == mrb_pkg::FAULT_CLEAR_KEY);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fault_q <= 16'h0000;
        end else if (fault_clear) begin
            fault_q <= i_fault_events & mrb_pkg::FAULT_VALID_MASK;
        end else begin
            fault_q <= fault_q | (i_fault_events & mrb_pkg::FAULT_VALID_MASK);
        end
    end

    mrb_period_meter u_period (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_spinning(i_spinning),
        .i_zero_cross_u(i_zero_cross_u),
        .o_update(),
        .o_period(period_val)
    );

    mrb_position_code u_position (
        .i_sector(i_ipd_sector),
        .i_advance_sel(nv_q[mrb_pkg::NV_ADV_SEL_ENTRY*16 + mrb_pkg::NV_ADV_SEL_LSB +: 2]),
        .o_code(position_code)
    );

    // Measured values; only hardware events move them
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            kt_q <= 16'h0000;
            position_q <= 8'h00;
            supply_q <= 8'h00;
            applied_q <= 8'h00;
            rate_q <= 16'h0000;
            current_q <= 11'h000;
            analog_q <= 10'h000;
        end else begin
            if (i_spinning && i_kt_done) begin
                kt_q <= i_kt_result;
            end
            if (i_ipd_done) begin
                position_q <= position_code;
            end
            if (i_spinning && i_supply_sample) begin
                supply_q <= i_supply_code;
            end
            applied_q <= i_applied_duty;
            rate_q <= i_rotation_rate;
            current_q <= i_winding_current;
            analog_q <= i_analog_adc;
        end
    end

    // Common speed request; manual select forces the serial value
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_speed_request_value <= 8'h00;
        end else if (rw_q[mrb_pkg::SETPOINT_MANUAL_SPEED_SELECT_BIT]
            || i_speed_src == mrb_pkg::SRC_SERIAL) begin
            o_speed_request_value <= rw_q[8:1];
        end else if (i_speed_src == mrb_pkg::SRC_ANALOG) begin
            o_speed_request_value <= i_analog_adc[9:2];
        end else begin
            o_speed_request_value <= i_pwm_duty_code;
        end
    end

    // Host and nonvolatile-backed registers, one entry per loop pass
    genvar gi;
    generate
        for (gi = 0; gi < mrb_pkg::RW_COUNT; gi++) begin : g_entry
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    rw_q[gi*16 +: 16] <= 16'h0000;
                    nv_q[gi*16 +: 16] <= mrb_pkg::NV_DEFAULTS[gi*16 +: 16];
                end else if (wr_stb_q) begin
                    if (ptr_q - 8'h01 == mrb_pkg::ADDR_RW_BASE + 8'(gi)) begin
                        rw_q[gi*16 +: 16] <= wdata_q;
                    end
                    if (ptr_q - 8'h01 == mrb_pkg::ADDR_NV_BASE + 8'(gi)) begin
                        nv_q[gi*16 +: 16] <= wdata_q;
                    end
                end
            end
        end
    endgenerate

    assign o_manual_speed_select = rw_q[mrb_pkg::SETPOINT_MANUAL_SPEED_SELECT_BIT];
    assign o_nvm_unlock_key = rw_q[31:16];

    // Read mux; status addresses have no write path except the fault clear at 0x00
    always_comb begin
        rdata = 16'h0000;
        case (ptr_q)
            mrb_pkg::ADDR_FAULT_FLAGS: rdata = fault_q;
            mrb_pkg::ADDR_ROTATION_RATE: rdata = rate_q;
            mrb_pkg::ADDR_ELECTRICAL_PERIOD: rdata = period_val;
            mrb_pkg::ADDR_VELOCITY_CONSTANT: rdata = kt_q;
            mrb_pkg::ADDR_WINDING_CURRENT: rdata = {5'h00, current_q};
            mrb_pkg::ADDR_POSITION_AND_SUPPLY: rdata = {position_q, supply_q};
            mrb_pkg::ADDR_SPEED_REQUEST_AND_BUFFER:
                rdata = {o_speed_request_value, applied_q};
            mrb_pkg::ADDR_ANALOG_INPUT_LEVEL: rdata = {6'h00, analog_q};
            mrb_pkg::ADDR_CHIP_IDENTITY:
                rdata = {mrb_pkg::DIE_IDENTIFIER, mrb_pkg::SILICON_REVISION_CODE};
            default: begin
                if (ptr_q >= mrb_pkg::ADDR_RW_BASE && ptr_q < mrb_pkg::ADDR_RW_BASE + 8'h07) begin
                    rdata = rw_q[(ptr_q - mrb_pkg::ADDR_RW_BASE)*16 +: 16];
                end else if (ptr_q >= mrb_pkg::ADDR_NV_BASE
                    && ptr_q < mrb_pkg::ADDR_NV_BASE + 8'h07) begin
                    rdata = nv_q[(ptr_q - mrb_pkg::ADDR_NV_BASE)*16 +: 16];
                end
            end
        endcase
    end

endmodule : mrb_readback_regs

// ### mrb_host_model.sv
// Two-wire bus host model: start, stop and nine-bit transfers.
// Assumes both lines pulled up; o_sda high means released.
`timescale 1ns/10ps
module mrb_host_model (
    input wire logic i_sys_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // SDA moves while SCL is low, except when framing
    task automatic hold(input logic scl, input logic sda);
        @(posedge i_sys_clk);
        if (scl)
            o_sda <= sda;
        else
            o_scl <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        if (scl)
            o_scl <= 1'b1;
        else
            o_sda <= sda;
        repeat (4) @(posedge i_sys_clk);
    endtask : hold
    task automatic start;
        hold(1'b0, 1'b1);
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
    endtask : start
    task automatic stop;
        hold(1'b0, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
    endtask : stop
    // Eight data bits then the acknowledge bit
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            hold(1'b0, tx[i]);
            hold(1'b1, tx[i]);
            rx[i] = i_sda;
        end
    endtask : xfer
endmodule : mrb_host_model

// ### mrb_readback_regs_chk.sv
// Port assertions for the readback bank.
// Assumes one clock domain; attached by the bind below.
`timescale 1ns/10ps
module mrb_readback_regs_chk (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [1:0] i_speed_src,
    input wire logic [7:0] i_pwm_duty_code,
    input wire logic [9:0] i_analog_adc,
    input wire logic [7:0] o_speed_request_value,
    input wire logic o_manual_speed_select,
    input wire logic [15:0] o_nvm_unlock_key
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_sda_open_drain: assert property (o_sda_oe |-> !o_sda_out)
        else $error("sda driven high");
    a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda moved while scl high");
    a_oe_min_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe [*4])
        else $error("sda bit too short");
    a_idle_after_stop: assert property (
        i_scl && $past(i_scl) && $rose(i_sda) |=> !o_sda_oe [*4])
        else $error("sda driven after stop");
    a_key_scl_low: assert property ($changed(o_nvm_unlock_key) |-> !i_scl)
        else $error("key changed outside write");
    a_select_scl_low: assert property ($changed(o_manual_speed_select) |-> !i_scl)
        else $error("select changed outside write");
    a_pwm_request: assert property (
        (!o_manual_speed_select && i_speed_src == 2'h0
        && $stable(i_pwm_duty_code)) [*4] |-> o_speed_request_value == i_pwm_duty_code)
        else $error("pwm request mismatch");
    a_adc_request: assert property (
        (!o_manual_speed_select && i_speed_src == 2'h1
        && $stable(i_analog_adc)) [*4] |-> o_speed_request_value == i_analog_adc[9:2])
        else $error("analog request mismatch");
endmodule : mrb_readback_regs_chk
bind mrb_readback_regs mrb_readback_regs_chk u_chk (.i_sys_clk, .i_nrst, .i_scl, .i_sda,
    .o_sda_out, .o_sda_oe, .i_speed_src, .i_pwm_duty_code, .i_analog_adc,
    .o_speed_request_value, .o_manual_speed_select, .o_nvm_unlock_key);

// ### mrb_readback_regs_test.sv
// Self-checking bench for the readback bank over its two-wire port.
// Assumes the host model drives SCL and SDA; both lines pulled up.
`timescale 1ns/10ps
module mrb_readback_regs_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic spin = 1'b1, zc = 1'b0, kt_done = 1'b0, ipd_done = 1'b0, sup_s = 1'b0;
    logic h_scl, h_sda, oe, sda_out, manual;
    logic [15:0] kt_res = 16'h0, faults = 16'h0, key;
    logic [2:0] sector = 3'h0;
    logic [7:0] sup = 8'h9c, pwm = 8'hc3, appl = 8'h7e, req;
    logic [9:0] adc = 10'h2d4;
    logic [1:0] src = 2'h0;
    logic [8:0] rx;
    logic [7:0] base [6] = '{8'h00, 8'h2b, 8'h55, 8'h80, 8'hab, 8'hd5};
    int error_cnt = 0, tests_run = 0, cycles = 0;
    wire sda = h_sda & ~oe;
    always #25 clk = ~clk;
    mrb_readback_regs dut (.i_sys_clk(clk), .i_nrst(nrst), .i_scl(h_scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(oe), .i_spinning(spin), .i_zero_cross_u(zc),
        .i_kt_done(kt_done), .i_kt_result(kt_res), .i_ipd_done(ipd_done),
        .i_ipd_sector(sector), .i_supply_sample(sup_s), .i_supply_code(sup),
        .i_speed_src(src), .i_pwm_duty_code(pwm), .i_analog_adc(adc),
        .i_applied_duty(appl), .i_rotation_rate(16'h01ff), .i_winding_current(11'h0a5),
        .i_fault_events(faults), .o_speed_request_value(req),
        .o_manual_speed_select(manual), .o_nvm_unlock_key(key));
    mrb_host_model host (.i_sys_clk(clk), .i_sda(sda), .o_scl(h_scl), .o_sda(h_sda));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] b);
        host.xfer({b, 1'b1}, rx);
        chk(16'(rx[0]), 16'h0);
    endtask : send
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.start();
        send({7'h52, 1'b0});
        send(a);
        send(d[15:8]);
        send(d[7:0]);
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        logic [7:0] hi;
        host.start();
        send({7'h52, 1'b0});
        send(a);
        host.start();
        send({7'h52, 1'b1});
        host.xfer(9'h1fe, rx);
        hi = rx[8:1];
        host.xfer(9'h1ff, rx);
        chk({hi, rx[8:1]}, exp);
        host.stop();
    endtask : rd
    task automatic inductive_position_detect(input logic [2:0] s, input logic [7:0] exp);
        @(posedge clk);
        sector <= s;
        sup <= {s, 5'h15};
        ipd_done <= 1'b1;
        sup_s <= 1'b1;
        @(posedge clk);
        ipd_done <= 1'b0;
        sup_s <= 1'b0;
        rd(8'h05, {exp, s, 5'h15});
    endtask : inductive_position_detect
    task automatic end_sim;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Whole run needs about 24000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            zc <= 1'b1;
            @(posedge clk);
            zc <= 1'b0;
            repeat (448) @(posedge clk);
        end
        rd(8'h02, 16'h0002);
        rd(8'h90, 16'h1048);
        rd(8'h96, 16'h016a);
        rd(8'h01, 16'h01ff);
        rd(8'h04, 16'h00a5);
        rd(8'h50, 16'h0000);
        rd(8'h06, {pwm, appl});
        host.start();
        host.xfer({7'h53, 1'b0, 1'b1}, rx);
        chk(16'(rx[0]), 16'h1);
        host.stop();
        @(posedge clk);
        kt_res <= 16'h2181;
        kt_done <= 1'b1;
        faults <= 16'h8061;
        @(posedge clk);
        kt_done <= 1'b0;
        faults <= 16'h0;
        rd(8'h03, 16'h2181);
        wr(8'h03, 16'hffff);
        rd(8'h03, 16'h2181);
        rd(8'h00, 16'h8021);
        wr(8'h00, 16'h00ff);
        rd(8'h00, 16'h0000);
        for (int s = 0; s < 6; s++)
            inductive_position_detect(3'(s), base[s] + 8'h16);
        wr(8'h96, 16'hc16a);
        inductive_position_detect(3'h5, 8'h2a);
        wr(8'h30, 16'h8055);
        chk(16'(manual), 16'h1);
        chk(16'(req), 16'h002a);
        rd(8'h30, 16'h8055);
        wr(8'h31, 16'h1234);
        chk(key, 16'h1234);
        rd(8'h31, 16'h1234);
        wr(8'h30, 16'h0055);
        src <= 2'h1;
        repeat (6) @(posedge clk);
        chk(16'(req), 16'(adc[9:2]));
        src <= 2'h2;
        repeat (6) @(posedge clk);
        chk(16'(req), 16'h002a);
        end_sim();
    end
endmodule : mrb_readback_regs_test
